//--- casc_timer_pkg.sv
// package: register map, field positions, reset values and mode codes of the cascaded timer
package casc_timer_pkg;

    // word byte addresses on the wishbone slave
    localparam logic [4:0] ADDR_LOWER_CTRL  = 5'h00;
    localparam logic [4:0] ADDR_UPPER_CTRL  = 5'h04;
    localparam logic [4:0] ADDR_WIDTH_LOW   = 5'h08;
    localparam logic [4:0] ADDR_WIDTH_HIGH  = 5'h0C;
    localparam logic [4:0] ADDR_PERIOD_LOW  = 5'h10;
    localparam logic [4:0] ADDR_PERIOD_HIGH = 5'h14;
    localparam logic [4:0] ADDR_STATUS      = 5'h18;
    localparam logic [4:0] ADDR_CLOCK_CTRL  = 5'h1C;

    // lower_stage_control fields
    localparam int SRC_LSB = 4;
    localparam int SRC_MSB = 6;
    // upper_stage_control fields
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 2;
    localparam int RUN_BIT  = 3;
    localparam int FLOP_BIT = 7;
    // system_clock_control field
    localparam int PSEL_BIT = 0;

    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [15:0] CMP_RESET   = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // source divisors from the core clock, taken as fc; fs is a tick input
    localparam int FC_DIV_11 = 2048;
    localparam int FC_DIV_7  = 128;
    localparam int FC_DIV_5  = 32;
    localparam int FC_DIV_3  = 8;
    localparam int FC_DIV_1  = 2;
    localparam int FS_DIV_3  = 8;
    localparam int PRESC_W   = 11;

    typedef enum logic [2:0]
    {
        MODE_WARMUP = 3'b101,
        MODE_PWM16  = 3'b110,
        MODE_PPG16  = 3'b111
    } mode_t;

    typedef enum logic [2:0]
    {
        SRC_SLOW_DIV = 3'b000,
        SRC_FC_7     = 3'b001,
        SRC_FC_5     = 3'b010,
        SRC_FC_3     = 3'b011,
        SRC_FS       = 3'b100,
        SRC_FC_1     = 3'b101,
        SRC_FC       = 3'b110,
        SRC_PIN      = 3'b111
    } src_t;

endpackage

//--- cmp_if.sv
// interface: compare values and shift-stage update between the counter core and the compare bank
`timescale 1ns/1ps
interface cmp_if;
    logic [15:0] width_cmp;
    logic [15:0] period_cmp;
    logic [15:0] width_shadow;
    logic        load_pulse;
    logic        buffered;

    modport bank
    (
        output width_cmp,
        output period_cmp,
        output width_shadow,
        input  load_pulse,
        input  buffered
    );
    modport core
    (
        input  width_cmp,
        input  period_cmp,
        input  width_shadow,
        output load_pulse,
        output buffered
    );
endinterface

//--- compare_bank.sv
// compare register bank: width shift stage, active width and period registers
`timescale 1ns/1ps
module compare_bank
    import casc_timer_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       wr_width_low,
    input  wire logic       wr_width_high,
    input  wire logic       wr_period_low,
    input  wire logic       wr_period_high,
    input  wire logic [7:0] wr_data,
    cmp_if.bank             cmp
);
    logic [15:0] shadow_r;
    logic [15:0] width_r;
    logic [15:0] period_r;

    assign cmp.width_shadow = shadow_r;
    assign cmp.width_cmp    = width_r;
    assign cmp.period_cmp   = period_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            shadow_r <= CMP_RESET;
        else if (wr_width_low)
            shadow_r <= {shadow_r[15:8], wr_data};
        else if (wr_width_high)
            shadow_r <= {wr_data, shadow_r[7:0]};
    end

    // width moves on the terminal event while buffered, else one cycle after a write
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            width_r <= CMP_RESET;
        else if (cmp.buffered ? cmp.load_pulse : 1'b1)
            width_r <= shadow_r;
    end

    // period is never buffered, so a new value acts at once
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            period_r <= CMP_RESET;
        else if (wr_period_low)
            period_r <= {period_r[15:8], wr_data};
        else if (wr_period_high)
            period_r <= {wr_data, period_r[7:0]};
    end
endmodule

//--- casc_timer.sv
// cascaded 16-bit pulse timer: pwm, ppg and warm-up modes behind a wishbone slave
`timescale 1ns/1ps
// Summary of operation
// - pwm: counter equals width value, toggle output flop, keep counting
// - pwm: on overflow toggle again, clear counter, raise irq
// - software presets output flop via control bit while stopped; reset clears flop to zero
// - pwm and ppg pins drive the inverse of the output flop
// - pwm width writes while running load at next irq; stopped, immediately
// - pwm width reads return the active width while running, the shift stage contents when stopped
// - stopped counter holds output pin at its level at stop
// - pwm accepts seven internal sources; slow modes only fs-derived ones
// - ppg counts the selected internal clock or the event pin
// - ppg: width match toggles flop; period match toggles, clears, raises irq
// - ppg width and period unbuffered, applied at once; host leaves them while running
// - warm-up compares only the upper eight bits of the period value
// - warm-up: once running, period match clears counter and raises irq
module casc_timer
    import casc_timer_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        fs_tick,
    input  wire logic        slow_mode,
    input  wire logic        event_input_pin,
    output logic             pulse_width_out_pin,
    output logic             pulse_gen_out_pin,
    output logic             cascade_timer_irq
);
    logic [7:0]         lower_stage_control_r;
    logic [7:0]         upper_stage_control_r;
    logic               system_clock_control_r;
    logic               irq_flag_r;
    logic               ack_r;
    logic [PRESC_W-1:0] presc_r;
    logic [2:0]         fs_cnt_r;
    logic               pin_s1_r;
    logic               pin_s2_r;
    logic               pin_prev_r;
    logic [7:0]         lower_cnt_r;
    logic [7:0]         upper_cnt_r;
    logic               output_toggle_flop_r;
    logic               run_prev_r;
    logic               tick_nxt;
    logic               pwm_mode;
    logic               ppg_mode;
    logic               warm_mode;
    logic               running;
    logic               overflow;
    logic               width_hit;
    logic               period_hit;
    logic               term_evt;
    logic               bus_req;
    logic               wr_upper;
    logic [2:0]         src;
    logic [15:0]        count;
    logic [15:0]        width_read;

    cmp_if cmp ();

    compare_bank u_bank
    (
        .core_clk       (core_clk),
        .rst            (rst),
        .wr_width_low   (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_WIDTH_LOW),
        .wr_width_high  (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_WIDTH_HIGH),
        .wr_period_low  (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_PERIOD_LOW),
        .wr_period_high (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_PERIOD_HIGH),
        .wr_data        (wb_dat_i[7:0]),
        .cmp            (cmp.bank)
    );

    function automatic logic div_edge(input logic [PRESC_W-1:0] p, input int div);
        div_edge = ((p & PRESC_W'(div - 1)) == '0);
    endfunction

    // single-cycle answer; bus_req only in the first cycle of each request
    assign bus_req  = wb_cyc_i && wb_stb_i && !ack_r;
    assign wb_ack_o = ack_r;
    assign wr_upper = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_UPPER_CTRL;

    assign src       = lower_stage_control_r[SRC_MSB:SRC_LSB];
    assign pwm_mode  = upper_stage_control_r[MODE_MSB:MODE_LSB] == MODE_PWM16;
    assign ppg_mode  = upper_stage_control_r[MODE_MSB:MODE_LSB] == MODE_PPG16;
    assign warm_mode = upper_stage_control_r[MODE_MSB:MODE_LSB] == MODE_WARMUP;
    assign running   = upper_stage_control_r[RUN_BIT];
    assign count     = {upper_cnt_r, lower_cnt_r};
    // a running pwm shows the width in force, so a fresh write stays hidden until the irq
    assign width_read = cmp.buffered ? cmp.width_cmp : cmp.width_shadow;

    assign cmp.buffered   = pwm_mode && running;
    assign cmp.load_pulse = term_evt && pwm_mode;

    // fc taken as core clock; fc-derived sources refused while the core runs slow, except fc itself in warm-up
    always_comb
    begin
        tick_nxt = 1'b0;
        case (src)
            SRC_SLOW_DIV:
                tick_nxt = system_clock_control_r || slow_mode ?
                           (fs_tick && fs_cnt_r == 3'(FS_DIV_3 - 1)) :
                           div_edge(presc_r, FC_DIV_11);
            SRC_FC_7: tick_nxt = !slow_mode && div_edge(presc_r, FC_DIV_7);
            SRC_FC_5: tick_nxt = !slow_mode && div_edge(presc_r, FC_DIV_5);
            SRC_FC_3: tick_nxt = !slow_mode && div_edge(presc_r, FC_DIV_3);
            SRC_FS:   tick_nxt = fs_tick;
            SRC_FC_1: tick_nxt = !slow_mode && div_edge(presc_r, FC_DIV_1);
            SRC_FC:   tick_nxt = !slow_mode || warm_mode;
            SRC_PIN:  tick_nxt = ppg_mode && pin_prev_r && !pin_s2_r;
            default:  tick_nxt = 1'b0;
        endcase
    end

    assign overflow   = tick_nxt && count == 16'hFFFF;
    assign width_hit  = tick_nxt && count == cmp.width_cmp;
    assign period_hit = tick_nxt &&
                        (warm_mode ? upper_cnt_r == cmp.period_cmp[15:8]
                                   : count == cmp.period_cmp);
    always_comb
    begin
        term_evt = 1'b0;
        if (running)
        begin
            if (pwm_mode)
                term_evt = overflow;
            else if (ppg_mode || warm_mode)
                term_evt = period_hit;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= bus_req;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            wb_dat_o <= '0;
        else if (bus_req && !wb_we_i)
        begin
            if (wb_adr_i == ADDR_LOWER_CTRL)
                wb_dat_o <= {24'h0000_00, lower_stage_control_r};
            else if (wb_adr_i == ADDR_UPPER_CTRL)
                wb_dat_o <= {24'h0000_00, upper_stage_control_r};
            else if (wb_adr_i == ADDR_WIDTH_LOW)
                wb_dat_o <= {24'h0000_00, width_read[7:0]};
            else if (wb_adr_i == ADDR_WIDTH_HIGH)
                wb_dat_o <= {24'h0000_00, width_read[15:8]};
            else if (wb_adr_i == ADDR_PERIOD_LOW)
                wb_dat_o <= {24'h0000_00, cmp.period_cmp[7:0]};
            else if (wb_adr_i == ADDR_PERIOD_HIGH)
                wb_dat_o <= {24'h0000_00, cmp.period_cmp[15:8]};
            else if (wb_adr_i == ADDR_STATUS)
                wb_dat_o <= {14'h0000, output_toggle_flop_r, irq_flag_r, count};
            else if (wb_adr_i == ADDR_CLOCK_CTRL)
                wb_dat_o <= {31'h0000_0000, system_clock_control_r};
            else
                wb_dat_o <= '0;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            lower_stage_control_r  <= CTRL_RESET;
            upper_stage_control_r  <= CTRL_RESET;
            system_clock_control_r <= 1'b0;
        end
        else if (bus_req && wb_we_i && wb_sel_i[0])
        begin
            if (wb_adr_i == ADDR_LOWER_CTRL)
                lower_stage_control_r <= wb_dat_i[7:0];
            else if (wb_adr_i == ADDR_UPPER_CTRL)
                upper_stage_control_r <= wb_dat_i[7:0];
            else if (wb_adr_i == ADDR_CLOCK_CTRL)
                system_clock_control_r <= wb_dat_i[PSEL_BIT];
        end
    end

    // status flag: a new terminal event wins over a read-clear in the same cycle
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            irq_flag_r <= 1'b0;
        else if (term_evt)
            irq_flag_r <= 1'b1;
        else if (bus_req && !wb_we_i && wb_adr_i == ADDR_STATUS)
            irq_flag_r <= 1'b0;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cascade_timer_irq <= 1'b0;
        else
            cascade_timer_irq <= term_evt;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            presc_r  <= '0;
            fs_cnt_r <= '0;
        end
        else
        begin
            presc_r <= presc_r + PRESC_W'(1);
            if (fs_tick)
                fs_cnt_r <= fs_cnt_r + 3'd1;
        end
    end

    // event pin is asynchronous; falling edge taken after two flops
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_r   <= 1'b1;
            pin_s2_r   <= 1'b1;
            pin_prev_r <= 1'b1;
        end
        else
        begin
            pin_s1_r   <= event_input_pin;
            pin_s2_r   <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            lower_cnt_r <= COUNT_RESET[7:0];
            upper_cnt_r <= COUNT_RESET[15:8];
        end
        else if (!running)
        begin
            lower_cnt_r <= COUNT_RESET[7:0];
            upper_cnt_r <= COUNT_RESET[15:8];
        end
        else if (term_evt)
        begin
            lower_cnt_r <= COUNT_RESET[7:0];
            upper_cnt_r <= COUNT_RESET[15:8];
        end
        else if (tick_nxt)
        begin
            lower_cnt_r <= lower_cnt_r + 8'd1;
            if (lower_cnt_r == 8'hFF)
                upper_cnt_r <= upper_cnt_r + 8'd1;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            run_prev_r <= 1'b0;
        else
            run_prev_r <= running;
    end

    // preset only from a write to a stopped timer so the stop level is held
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            output_toggle_flop_r <= 1'b0;
        else if (wr_upper && !running && !run_prev_r && !wb_dat_i[RUN_BIT])
            output_toggle_flop_r <= wb_dat_i[FLOP_BIT];
        else if (wr_upper && !running && wb_dat_i[RUN_BIT] && !run_prev_r)
            output_toggle_flop_r <= wb_dat_i[FLOP_BIT];
        else if (running && (pwm_mode || ppg_mode))
        begin
            if (term_evt || (width_hit && !term_evt))
                output_toggle_flop_r <= !output_toggle_flop_r;
        end
    end

    // pins held high outside their modes; in mode they show the inverted flop
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pulse_width_out_pin <= 1'b1;
            pulse_gen_out_pin   <= 1'b1;
        end
        else
        begin
            pulse_width_out_pin <= pwm_mode ? !output_toggle_flop_r : 1'b1;
            pulse_gen_out_pin   <= ppg_mode ? !output_toggle_flop_r : 1'b1;
        end
    end
endmodule

//--- casc_timer_partner.sv
// partner model: low-frequency tick source and external event pin
`timescale 1ns/1ps
module pin_partner
#(
    parameter int FS_PERIOD = 4
)
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ev_en,
    input  wire logic [3:0] ev_half,
    output logic            fs_tick,
    output logic            event_input_pin
);
    logic [3:0] fs_cnt_r;
    logic [3:0] ev_cnt_r;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            fs_cnt_r <= 4'h0;
            fs_tick  <= 1'b0;
        end
        else
        begin
            fs_cnt_r <= (fs_cnt_r == 4'(FS_PERIOD - 1)) ? 4'h0 : fs_cnt_r + 4'h1;
            fs_tick  <= (fs_cnt_r == 4'(FS_PERIOD - 1));
        end
    end

    // each level lasts ev_half cycles, sixteen when ev_half is zero; idle high between bursts
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst || !ev_en)
        begin
            ev_cnt_r        <= 4'h0;
            event_input_pin <= 1'b1;
        end
        else if (ev_cnt_r == ev_half - 4'h1)
        begin
            ev_cnt_r        <= 4'h0;
            event_input_pin <= ~event_input_pin;
        end
        else
            ev_cnt_r <= ev_cnt_r + 4'h1;
    end
endmodule

//--- casc_timer_asserts.sv
// checker: port-level properties of the cascaded pulse timer
`timescale 1ns/1ps
module casc_timer_checker
    import casc_timer_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [4:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        fs_tick,
    input wire logic        slow_mode,
    input wire logic        event_input_pin,
    input wire logic        pulse_width_out_pin,
    input wire logic        pulse_gen_out_pin,
    input wire logic        cascade_timer_irq
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic       run_r;
    logic [2:0] quiet_r;
    logic       ctl_wr;

    assign ctl_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_UPPER_CTRL;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            run_r <= 1'b0;
        else if (ctl_wr)
            run_r <= wb_dat_i[RUN_BIT];
    end

    // a control write may preset the flop, so only settled stopped spans count
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst || run_r || ctl_wr)
            quiet_r <= 3'h0;
        else if (quiet_r != 3'h7)
            quiet_r <= quiet_r + 3'h1;
    end

    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'b00
        |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
    irq_pulse_a: assert property (cascade_timer_irq |=> !cascade_timer_irq)
        else $error("irq longer than one cycle");
    reset_pins_a: assert property ($past(rst) |-> pulse_width_out_pin && pulse_gen_out_pin
        && !cascade_timer_irq) else $error("pins or irq wrong after reset");
    pins_apart_a: assert property (pulse_width_out_pin || pulse_gen_out_pin)
        else $error("both output pins low");
    stopped_quiet_a: assert property (cascade_timer_irq
        |-> run_r || $past(run_r) || $past(run_r, 2)) else $error("irq while stopped");
    stopped_hold_a: assert property (quiet_r == 3'h7
        |-> $stable(pulse_width_out_pin) && $stable(pulse_gen_out_pin))
        else $error("pin moved while stopped");

    cover property (cascade_timer_irq);
    cover property ($fell(pulse_gen_out_pin));
    cover property ($fell(pulse_width_out_pin));
endmodule

//--- casc_timer_bench.sv
// testbench: wishbone-driven scenarios for the cascaded pulse timer
`timescale 1ns/1ps
module casc_timer_bench
    import casc_timer_pkg::*;
;
    logic        core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, ev_en, wb_ack_o;
    logic        fs_tick, slow_mode, event_input_pin, cascade_timer_irq;
    logic        pulse_width_out_pin, pulse_gen_out_pin;
    logic [4:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd_q;
    int          num_errors, check_count, cycles;

    casc_timer dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fs_tick(fs_tick), .slow_mode(slow_mode),
        .event_input_pin(event_input_pin), .pulse_width_out_pin(pulse_width_out_pin),
        .pulse_gen_out_pin(pulse_gen_out_pin), .cascade_timer_irq(cascade_timer_irq));
    pin_partner #(.FS_PERIOD(4)) peer (.core_clk(core_clk), .rst(rst), .ev_en(ev_en),
        .ev_half(4'h3), .fs_tick(fs_tick), .event_input_pin(event_input_pin));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // the longest scenario is one full 16-bit pwm period
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        do
            @(posedge core_clk);
        while (wb_ack_o !== 1'b1);
        rd_q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // low byte first, then high byte, never one alone
    task automatic wr16(input logic [4:0] a, input logic [15:0] v);
        bus(a, 1'b1, v[7:0]);
        bus(a + 5'h04, 1'b1, v[15:8]);
    endtask

    // irq to irq span, with low cycles of each pin
    task automatic span(output int len, output int lw, output int lg);
        for (int k = 0; k < 2; k++)
        begin
            len = 0;
            lw = 0;
            lg = 0;
            do
            begin
                @(posedge core_clk);
                len++;
                lw += int'(pulse_width_out_pin === 1'b0);
                lg += int'(pulse_gen_out_pin === 1'b0);
            end
            while (cascade_timer_irq !== 1'b1);
        end
    endtask

    task automatic t_reset();
        logic [4:0] regs [6] = '{ADDR_WIDTH_LOW, ADDR_WIDTH_HIGH, ADDR_PERIOD_LOW,
                                 ADDR_PERIOD_HIGH, ADDR_LOWER_CTRL, ADDR_UPPER_CTRL};
        for (int i = 0; i < 6; i++)
        begin
            bus(regs[i], 1'b0, 8'h00);
            check("reset value", 32'(rd_q[7:0]), 32'(i < 4 ? CMP_RESET[7:0] : CTRL_RESET));
        end
        bus(ADDR_STATUS, 1'b0, 8'h00);
        check("flop at reset", 32'(rd_q[17]), 32'h0000_0000);
        check("idle pins", 32'({pulse_width_out_pin, pulse_gen_out_pin}), 32'h0000_0003);
        bus(5'h1E, 1'b1, 8'h5A);
        bus(5'h1E, 1'b0, 8'h00);
        check("unmapped read", rd_q, 32'h0000_0000);
    endtask

    task automatic t_ppg();
        int   len, lw, lg;
        logic p;
        wr16(ADDR_WIDTH_LOW, 16'h0003);
        wr16(ADDR_PERIOD_LOW, 16'h000A);
        bus(ADDR_LOWER_CTRL, 1'b1, 8'h60);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h0F);
        span(len, lw, lg);
        check("ppg period", len, 11);
        check("ppg low time", lg, 7);
        check("pwm pin in ppg", lw, 0);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h07);
        repeat (3) @(posedge core_clk);
        p = pulse_gen_out_pin;
        repeat (10) @(posedge core_clk);
        check("held pin", 32'(pulse_gen_out_pin), 32'(p));
        bus(ADDR_STATUS, 1'b0, 8'h00);
        check("flop vs pin", 32'(rd_q[17]), 32'(!p));
        check("irq flag", 32'(rd_q[16]), 32'h0000_0001);
        check("stopped count", 32'(rd_q[15:0]), 32'h0000_0000);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h87);
        repeat (3) @(posedge core_clk);
        check("preset pin", 32'(pulse_gen_out_pin), 32'h0000_0000);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h07);
        bus(ADDR_WIDTH_LOW, 1'b0, 8'h00);
        check("width kept", 32'(rd_q[7:0]), 32'h0000_0003);
    endtask

    task automatic t_event();
        int len, lw, lg;
        wr16(ADDR_WIDTH_LOW, 16'h0001);
        wr16(ADDR_PERIOD_LOW, 16'h0004);
        bus(ADDR_LOWER_CTRL, 1'b1, 8'h70);
        ev_en <= 1'b1;
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h0F);
        span(len, lw, lg);
        check("event period", len, 30);
        check("event low time", lg, 18);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h07);
        ev_en <= 1'b0;
    endtask

    task automatic t_warm();
        int len, lw, lg;
        wr16(ADDR_PERIOD_LOW, 16'h0137);
        bus(ADDR_LOWER_CTRL, 1'b1, 8'h40);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h0D);
        span(len, lw, lg);
        check("warm-up period", len, 1028);
        check("warm-up pins", lw + lg, 0);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h05);
        slow_mode <= 1'b1;
        wr16(ADDR_PERIOD_LOW, 16'h0002);
        bus(ADDR_LOWER_CTRL, 1'b1, 8'h00);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h0F);
        span(len, lw, lg);
        check("slow source period", len, 96);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h05);
        wr16(ADDR_PERIOD_LOW, 16'h0100);
        bus(ADDR_LOWER_CTRL, 1'b1, 8'h60);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h0D);
        span(len, lw, lg);
        check("fast warm-up period", len, 257);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h05);
        slow_mode <= 1'b0;
    endtask

    task automatic t_pwm();
        int   low;
        logic hit;
        wr16(ADDR_WIDTH_LOW, 16'h0010);
        bus(ADDR_WIDTH_LOW, 1'b0, 8'h00);
        check("stopped width", 32'(rd_q[7:0]), 32'h0000_0010);
        bus(ADDR_LOWER_CTRL, 1'b1, 8'h60);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h0E);
        wr16(ADDR_WIDTH_LOW, 16'h0020);
        bus(ADDR_WIDTH_LOW, 1'b0, 8'h00);
        check("running width", 32'(rd_q[7:0]), 32'h0000_0010);
        low = 0;
        hit = 1'b0;
        do
        begin
            @(posedge core_clk);
            low += int'(pulse_width_out_pin === 1'b0);
            hit |= (cascade_timer_irq === 1'b1);
        end
        while (!(hit && low > 0 && pulse_width_out_pin === 1'b1));
        check("pwm low time", low, 65519);
        bus(ADDR_WIDTH_LOW, 1'b0, 8'h00);
        check("shifted width", 32'(rd_q[7:0]), 32'h0000_0020);
        bus(ADDR_UPPER_CTRL, 1'b1, 8'h06);
    endtask

    initial
    begin
        rst         = 1'b1;
        wb_cyc_i    = 1'b0;
        wb_stb_i    = 1'b0;
        wb_we_i     = 1'b0;
        wb_adr_i    = 5'h00;
        wb_sel_i    = 4'h1;
        wb_dat_i    = 32'h0000_0000;
        slow_mode   = 1'b0;
        ev_en       = 1'b0;
        num_errors  = 0;
        check_count = 0;
        cycles      = 0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_ppg();
        t_event();
        t_warm();
        t_pwm();
        complete_run();
    end
endmodule

bind casc_timer casc_timer_checker chk (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fs_tick(fs_tick),
    .slow_mode(slow_mode), .event_input_pin(event_input_pin),
    .pulse_width_out_pin(pulse_width_out_pin), .pulse_gen_out_pin(pulse_gen_out_pin),
    .cascade_timer_irq(cascade_timer_irq));
